// file: verilog/crr_pkg.sv
// Package of register offsets, fields, reset values and timing constants for the result readout
package crr_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_RANGE_UPPER = 8'h01;
  localparam logic [7:0] OFS_RANGE_LOWER = 8'h02;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_POWER = 8'h0B;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_PROX_LOW = 8'h21;
  localparam logic [7:0] OFS_PROX_HIGH = 8'h22;
  localparam logic [7:0] OFS_FREQ_LOW = 8'h23;
  localparam logic [7:0] OFS_FREQ_MID = 8'h24;
  localparam logic [7:0] OFS_FREQ_HIGH = 8'h25;
  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [7:0] RST_RANGE_LOWER = 8'h14;
  localparam logic [7:0] RST_RANGE_UPPER = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_POWER = 8'h00;
  localparam int RESP_LSB = 0;
  localparam int RESP_W = 3;
  localparam int POWER_BIT = 0;
  localparam int STAT_READY_BIT = 6;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam logic [15:0] RESP_BASE = 16'h00C0;
  localparam logic [15:0] RESP_DIV = 16'h0003;
  localparam int PROX_W = 16;
  localparam int FREQ_W = 24;
endpackage

// file: verilog/crr_conv_engine.sv
// Conversion timer: counts sensor periods per conversion, measures frequency count, clips result
`timescale 1ns/1ps
module crr_conv_engine #(
  parameter int PROX_W = 16,
  parameter int FREQ_W = 24
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic sens_edge,
  input wire logic [15:0] conv_len,
  input wire logic [PROX_W-1:0] meas,
  input wire logic [PROX_W-1:0] lim_lower,
  input wire logic [PROX_W-1:0] lim_upper,
  output logic done,
  output logic [PROX_W-1:0] prox,
  output logic [FREQ_W-1:0] freq
);
  logic [15:0] edge_cnt_reg, edge_cnt_next;
  logic [FREQ_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic done_reg, done_next;
  logic [PROX_W-1:0] prox_reg, prox_next;
  logic [FREQ_W-1:0] freq_reg, freq_next;
  logic [PROX_W-1:0] clipped;

  // ----------------------------------------
  // Window counting
  // ----------------------------------------
  always_comb begin
    // Out-of-range impedance is pinned to the nearest limit [R5]
    if (meas < lim_lower) begin
      clipped = lim_lower;
    end else if (meas > lim_upper) begin
      clipped = lim_upper;
    end else begin
      clipped = meas;
    end
    edge_cnt_next = edge_cnt_reg;
    tick_cnt_next = tick_cnt_reg;
    done_next = 1'b0;
    prox_next = prox_reg;
    freq_next = freq_reg;
    if (!run) begin
      // Standby holds the timer idle [R10]
      edge_cnt_next = '0;
      tick_cnt_next = '0;
    end else begin
      if (tick_cnt_reg != '1) begin
        tick_cnt_next = tick_cnt_reg + 1'b1;
      end
      if (sens_edge) begin
        // One result per conv_len sensor periods [R8]
        if (edge_cnt_reg + 16'h0001 >= conv_len) begin
          edge_cnt_next = '0;
          tick_cnt_next = '0;
          done_next = 1'b1;
          prox_next = clipped;
          freq_next = tick_cnt_reg;
        end else begin
          edge_cnt_next = edge_cnt_reg + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt_reg <= '0;
      tick_cnt_reg <= '0;
      done_reg <= 1'b0;
      prox_reg <= '0;
      freq_reg <= '0;
    end else begin
      edge_cnt_reg <= edge_cnt_next;
      tick_cnt_reg <= tick_cnt_next;
      done_reg <= done_next;
      prox_reg <= prox_next;
      freq_reg <= freq_next;
    end
  end

  assign done = done_reg;
  assign prox = prox_reg;
  assign freq = freq_reg;
endmodule

// file: verilog/crr_result_readout.sv
// Result readout: byte register file, range limits, power state and result snapshot
//
// Contract
// R1: Frequency count bits 23..16 read back, read-only, at offset 0x25.
// R2: Results copy into readout registers only when a read of 0x21 starts.
// R3: Conversions finishing without a 0x21 read leave the latched snapshot untouched.
// R4: Host reads all result bytes of one conversion, beginning at 0x21.
// R5: Impedance outside the lower/upper limits is clipped to those limits.
// R6: Lower limit resets to 0x14; host reprograms it before enabling conversions.
// R7: Host writes only permitted limit codes; other codes are undefined.
// R8: Result rate is sensor frequency over one third of response time.
// R9: Proximity low byte reads back, read-only, at offset 0x21.
// R10: Conversions run only while power state select is 1.
// R11: Status bit, active low, shows new conversion data available; a result latched at 0x21 in its done cycle stays flagged.
// R12: After a 0x21 read, all result bytes return that same snapshot.
`timescale 1ns/1ps
module crr_result_readout (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sensor_osc,
  input wire logic [crr_pkg::PROX_W-1:0] meas_imp,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic data_ready_n
);
  import crr_pkg::*;

  // ----------------------------------------
  // Sensor oscillator synchroniser
  // ----------------------------------------
  logic osc_s1_reg, osc_s1_next;
  logic osc_s2_reg, osc_s2_next;
  logic osc_s3_reg, osc_s3_next;
  logic sens_edge;

  always_comb begin
    // Only the second and third stages feed logic; the first may still be settling
    osc_s1_next = sensor_osc;
    osc_s2_next = osc_s1_reg;
    osc_s3_next = osc_s2_reg;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end else begin
      osc_s1_reg <= osc_s1_next;
      osc_s2_reg <= osc_s2_next;
      osc_s3_reg <= osc_s3_next;
    end
  end

  // Only edges below half of mclk are counted faithfully
  assign sens_edge = osc_s2_reg & ~osc_s3_reg;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] upper_reg, upper_next;
  logic [7:0] lower_reg, lower_next;
  logic [7:0] config_reg, config_next;
  logic [7:0] power_reg, power_next;

  always_comb begin
    upper_next = upper_reg;
    lower_next = lower_reg;
    config_next = config_reg;
    power_next = power_reg;
    // Limit codes are trusted as written; no legality check in hardware [R7]
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_RANGE_UPPER: upper_next = reg_wdata;
        OFS_RANGE_LOWER: lower_next = reg_wdata;
        OFS_CONFIG: config_next = reg_wdata;
        OFS_POWER: power_next = {7'h00, reg_wdata[POWER_BIT]};
        // Result and status offsets are read-only, so writes there are dropped
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      upper_reg <= RST_RANGE_UPPER;
      lower_reg <= RST_RANGE_LOWER; // [R6]
      config_reg <= RST_CONFIG;
      power_reg <= RST_POWER;
    end else begin
      upper_reg <= upper_next;
      lower_reg <= lower_next;
      config_reg <= config_next;
      power_reg <= power_next;
    end
  end

  // ----------------------------------------
  // Conversion engine
  // ----------------------------------------
  logic [RESP_W-1:0] resp_code;
  logic [15:0] resp_time;
  logic [15:0] conv_len;
  logic conv_done;
  logic [PROX_W-1:0] conv_prox;
  logic [FREQ_W-1:0] conv_freq;
  logic run_en;

  // Standby clears the window counters, so no result spans a power toggle [R10]
  assign run_en = power_reg[POWER_BIT];
  assign resp_code = config_reg[RESP_LSB +: RESP_W];
  // Response time doubles per code step from its base; divider of three per result [R8]
  assign resp_time = RESP_BASE << resp_code;
  assign conv_len = resp_time / RESP_DIV;

  crr_conv_engine #(
    .PROX_W(PROX_W),
    .FREQ_W(FREQ_W)
  ) crr_conv_engine_inst (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(run_en),
    .sens_edge(sens_edge),
    .conv_len(conv_len),
    .meas(meas_imp),
    .lim_lower({lower_reg, ZERO_BYTE}), // [R5]
    .lim_upper({upper_reg, ZERO_BYTE}),
    .done(conv_done),
    .prox(conv_prox),
    .freq(conv_freq)
  );

  // ----------------------------------------
  // Snapshot and ready flag
  // ----------------------------------------
  logic [PROX_W-1:0] snap_prox_reg, snap_prox_next;
  logic [FREQ_W-1:0] snap_freq_reg, snap_freq_next;
  logic ready_n_reg, ready_n_next;
  logic latch_now;

  // Host is expected to start each result burst here [R4]
  assign latch_now = reg_rd && (reg_addr == OFS_PROX_LOW);

  always_comb begin
    snap_prox_next = snap_prox_reg;
    snap_freq_next = snap_freq_reg;
    ready_n_next = ready_n_reg;
    // Copy only at the start of a low-byte read; later conversions wait [R2] [R3]
    if (latch_now) begin
      snap_prox_next = conv_prox;
      snap_freq_next = conv_freq;
      ready_n_next = 1'b1;
    end
    // A result finishing in the latch cycle still flags as new [R11]
    if (conv_done) begin
      ready_n_next = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      snap_prox_reg <= '0;
      snap_freq_reg <= '0;
      ready_n_reg <= 1'b1;
    end else begin
      snap_prox_reg <= snap_prox_next;
      snap_freq_reg <= snap_freq_next;
      ready_n_reg <= ready_n_next;
    end
  end

  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  logic [7:0] status_byte;

  always_comb begin
    // Oscillator, wake-up and comparator flags are not modelled and read as fixed levels
    status_byte = 8'h3F;
    status_byte[STAT_READY_BIT] = ready_n_reg; // [R11]
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_RANGE_UPPER: rdata_next = upper_reg;
        OFS_RANGE_LOWER: rdata_next = lower_reg;
        OFS_CONFIG: rdata_next = config_reg;
        OFS_POWER: rdata_next = power_reg;
        OFS_STATUS: rdata_next = status_byte;
        // Taken live, so it belongs to the very result latched on this same edge
        OFS_PROX_LOW: rdata_next = conv_prox[7:0]; // [R9] [R2]
        OFS_PROX_HIGH: rdata_next = snap_prox_reg[15:8]; // [R12]
        OFS_FREQ_LOW: rdata_next = snap_freq_reg[7:0]; // [R12]
        OFS_FREQ_MID: rdata_next = snap_freq_reg[15:8]; // [R12]
        OFS_FREQ_HIGH: rdata_next = snap_freq_reg[23:16]; // [R1]
        default: rdata_next = ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= ZERO_BYTE;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Every output leaves straight from a register
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign data_ready_n = ready_n_reg;
endmodule

// file: verification/crr_result_readout_asserts.sv
// Checker of the result readout port relations
`timescale 1ns/1ps
module crr_result_readout_asserts
  import crr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic data_ready_n
);
  logic pwr_reg, pwr_next, ok_reg, ok_next, rdh_reg, rdh_next;
  logic [7:0] hi_reg, hi_next;
  // ----
  // Shadow of power state and last high count byte
  // ----
  always_comb begin
    pwr_next = pwr_reg;
    hi_next = hi_reg;
    ok_next = ok_reg;
    rdh_next = reg_rd & (reg_addr == OFS_FREQ_HIGH);
    if (reg_wr && reg_addr == OFS_POWER) begin
      pwr_next = reg_wdata[POWER_BIT];
    end
    if (reg_rvalid && rdh_reg) begin
      hi_next = reg_rdata;
      ok_next = 1'b1;
    end
    // A new latch invalidates the shadow
    if (reg_rd && reg_addr == OFS_PROX_LOW) begin
      ok_next = 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {pwr_reg, ok_reg, rdh_reg, hi_reg} <= '0;
    end else begin
      {pwr_reg, ok_reg, rdh_reg, hi_reg} <= {pwr_next, ok_next, rdh_next, hi_next};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_answer; reg_rd |=> reg_rvalid; endproperty
  property p_nospur; reg_rvalid |-> $past(reg_rd); endproperty
  property p_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
  property p_unmap; reg_rd && reg_addr > OFS_FREQ_HIGH |=> reg_rdata == 8'h00; endproperty
  property p_stat; reg_rd && reg_addr == OFS_STATUS |=> reg_rdata == {1'b0, $past(data_ready_n), 6'h3F}; endproperty
  property p_rise; $rose(data_ready_n) |-> $past(reg_rd && reg_addr == OFS_PROX_LOW); endproperty
  property p_off; $fell(data_ready_n) |-> $past(pwr_reg, 4); endproperty
  property p_snap; reg_rvalid && rdh_reg && ok_reg |-> reg_rdata == hi_reg; endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  a_nospur: assert property (p_nospur) else $error("read data without request");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_stat: assert property (p_stat) else $error("status byte wrong");
  a_rise: assert property (p_rise) else $error("ready cleared without latch");
  a_off: assert property (p_off) else $error("new data in standby");
  a_snap: assert property (p_snap) else $error("snapshot changed");
  c_latch: cover property (reg_rd && reg_addr == OFS_PROX_LOW && !data_ready_n);
  c_new: cover property ($fell(data_ready_n));
  c_snap: cover property (reg_rvalid && rdh_reg && ok_reg);
endmodule
bind crr_result_readout crr_result_readout_asserts crr_result_readout_asserts_inst (.mclk(mclk), .rst_n(rst_n),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .data_ready_n(data_ready_n));

// file: verification/crr_sensor_model.sv
// Sensor front end model: free running tank and held impedance code
`timescale 1ns/1ps
module crr_sensor_model #(
  parameter int HALF_NS = 32
) (
  input wire logic [15:0] level,
  output logic sensor_osc,
  output logic [15:0] meas_imp
);
  // The tank never stops, so edges run outside conversions too
  initial begin
    sensor_osc = 1'b0;
    #3;
    forever #HALF_NS sensor_osc = ~sensor_osc;
  end
  assign meas_imp = level;
endmodule

// file: verification/tb_crr_result_readout.sv
// Self-checking bench of the result readout
`timescale 1ns/1ps
module tb_crr_result_readout;
  import crr_pkg::*;
  logic mclk = 0, rst_n = 0, reg_rd = 0, reg_wr = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [15:0] level = 16'h0000;
  logic [15:0] exp_q[$];
  wire sensor_osc, reg_rvalid, data_ready_n;
  wire [15:0] meas_imp;
  wire [7:0] reg_rdata;
  int num_errors = 0, comparisons = 0, cyc = 0, seed = 32'hb1469d6c;
  always #4 mclk = ~mclk;
  crr_sensor_model crr_sensor_model_inst (.level(level), .sensor_osc(sensor_osc), .meas_imp(meas_imp));
  crr_result_readout crr_result_readout_inst (.mclk(mclk), .rst_n(rst_n), .sensor_osc(sensor_osc),
    .meas_imp(meas_imp), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .data_ready_n(data_ready_n));
  // ----
  // Tasks
  // ----
  task automatic chk(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Mask bits set to 1 are compared
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge mclk) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    exp_q.push_back({m, e});
    @(posedge mclk) #1;
    reg_rd = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk) #1;
    reg_wr = 1'b0;
  endtask
  task automatic wait_ready(output int n);
    n = 0;
    while (data_ready_n !== 1'b0 && n < 3000) begin
      @(posedge mclk) #1;
      n++;
    end
    chk(n < 3000, "no new data");
  endtask
  function automatic logic [15:0] clip(input logic [15:0] v);
    return (v < 16'h1000) ? 16'h1000 : ((v > 16'h8000) ? 16'h8000 : v);
  endfunction
  always @(negedge mclk) begin
    if (reg_rvalid === 1'b1) begin
      chk(exp_q.size() > 0 && ((reg_rdata ^ exp_q[0][7:0]) & exp_q[0][15:8]) === 8'h00, "read data");
      if (exp_q.size() > 0) begin
        void'(exp_q.pop_front());
      end
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("MISMATCH at %0t: timeout", $time);
      tally_and_finish();
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    logic [15:0] m0, m1, p0, p1;
    logic [23:0] f;
    int n;
    repeat (16) @(posedge mclk);
    #1 rst_n = 1'b1;
    rd(OFS_RANGE_LOWER, RST_RANGE_LOWER, 8'hFF);
    rd(OFS_POWER, 8'h00, 8'hFF);
    rd(8'h30, 8'h00, 8'hFF);
    wr(OFS_FREQ_HIGH, 8'hFF);
    rd(OFS_FREQ_HIGH, 8'h00, 8'hFF);
    repeat (600) @(posedge mclk);
    rd(OFS_STATUS, 8'h7F, 8'hFF);
    wr(OFS_RANGE_LOWER, 8'h10);
    wr(OFS_RANGE_UPPER, 8'h80);
    rd(OFS_RANGE_UPPER, 8'h80, 8'hFF);
    for (int c = 0; c < 2; c++) begin
      m0 = 16'($random(seed)) & 16'h0FFF;
      m0 = (c == 0) ? m0 : (m0 | 16'h2000);
      m1 = 16'h8000 | 16'($random(seed));
      p0 = clip(m0);
      p1 = clip(m1);
      // Ticks run from the cycle after the opening edge up to the closing edge
      f = (24'd512 << c) - 24'd1;
      level = m0;
      wr(OFS_CONFIG, 8'(c));
      rd(OFS_CONFIG, 8'(c), 8'hFF);
      wr(OFS_POWER, 8'h01);
      wait_ready(n);
      rd(OFS_PROX_LOW, p0[7:0], 8'hFF);
      wait_ready(n);
      chk(n > (512 << c) - 40 && n <= (512 << c), "result rate");
      rd(OFS_PROX_LOW, p0[7:0], 8'hFF);
      rd(OFS_PROX_HIGH, p0[15:8], 8'hFF);
      rd(OFS_FREQ_LOW, f[7:0], 8'hFF);
      rd(OFS_FREQ_MID, f[15:8], 8'hFF);
      rd(OFS_FREQ_HIGH, f[23:16], 8'hFF);
      level = m1;
      wait_ready(n);
      repeat (600 << c) @(posedge mclk);
      rd(OFS_PROX_HIGH, p0[15:8], 8'hFF);
      rd(OFS_FREQ_MID, f[15:8], 8'hFF);
      rd(OFS_FREQ_HIGH, f[23:16], 8'hFF);
      rd(OFS_STATUS, 8'h3F, 8'hFF);
      rd(OFS_PROX_LOW, p1[7:0], 8'hFF);
      rd(OFS_PROX_HIGH, p1[15:8], 8'hFF);
      wr(OFS_POWER, 8'h00);
    end
    repeat (4) @(posedge mclk);
    chk(exp_q.size() == 0, "reads left unanswered");
    tally_and_finish();
  end
endmodule
